/* File: rtl/cpmc_pkg.sv */
/*
  Shared constants for the privilege and mode control block.
  Assumes a single core clock domain; included before the modules.
*/
package cpmc_pkg;
  // Combined level and mode states
  typedef enum logic [1:0] {
    CPMC_PRIV_THREAD = 2'b00,
    CPMC_USER_THREAD = 2'b01,
    CPMC_PRIV_HANDLR = 2'b10
  } cpmc_state_e;

  // Mode control register fields and reset value
  localparam int          CPMC_CTRL_W       = 2;
  localparam int          CPMC_CTRL_NPRIV   = 0;
  localparam int          CPMC_CTRL_SPSEL   = 1;
  localparam logic [1:0]  CPMC_CTRL_RST     = 2'h0;
  // Execution status register: compact instruction state bit
  localparam int          CPMC_ESR_TBIT     = 24;
  localparam logic [31:0] CPMC_ESR_RST      = 32'h01000000;
  // Stack pointers, word aligned
  localparam logic [31:0] CPMC_SP_RST       = 32'h00000000;
  localparam logic [31:0] CPMC_SP_ALIGN     = 32'hFFFFFFFC;
  // Address map region bases (top three bits), 4 GB space
  localparam logic [2:0]  CPMC_REG_CODE     = 3'h0;
  localparam logic [2:0]  CPMC_REG_SRAM     = 3'h1;
  localparam logic [2:0]  CPMC_REG_PERI     = 3'h2;
  localparam logic [2:0]  CPMC_REG_SYS      = 3'h7;
  // Bit-band alias window offsets and lock length
  localparam logic [7:0]  CPMC_BB_SRAM      = 8'h22;
  localparam logic [7:0]  CPMC_BB_PERI      = 8'h42;
  localparam int          CPMC_BB_LOCK_CYC  = 2;
  // Instruction encoding classes
  localparam logic [4:0]  CPMC_WIDE_PFX0    = 5'h1D;
  localparam logic [4:0]  CPMC_WIDE_PFX1    = 5'h1E;
  localparam logic [4:0]  CPMC_WIDE_PFX2    = 5'h1F;
endpackage

/* File: rtl/cpmc_sp_bank.sv */
/*
  Banked pair of stack pointers, main and process.
  Assumes the caller gives the selection and one write strobe.
*/
`timescale 1ns/1ps
module cpmc_sp_bank
  import cpmc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Selection and write
  input  wire logic        sel_process,
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_data,
  // Read data
  output logic [31:0] sp_value,
  output logic [31:0] main_sp,
  output logic [31:0] proc_sp
);
  logic [31:0] main_stack_pointer_r, main_stack_pointer_nxt;
  logic [31:0] process_stack_pointer_r, process_stack_pointer_nxt;
  logic [31:0] sp_value_r, sp_value_nxt;

  // Write the selected pointer, low two bits forced to zero
  always_comb begin
    main_stack_pointer_nxt    = main_stack_pointer_r;
    process_stack_pointer_nxt = process_stack_pointer_r;
    if (wr_en && sel_process) begin
      process_stack_pointer_nxt = wr_data & CPMC_SP_ALIGN;
    end else if (wr_en) begin
      main_stack_pointer_nxt = wr_data & CPMC_SP_ALIGN;
    end
    sp_value_nxt = sel_process ? process_stack_pointer_nxt
                               : main_stack_pointer_nxt;
  end

  // Register the bank and the selected read value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      main_stack_pointer_r    <= CPMC_SP_RST;
      process_stack_pointer_r <= CPMC_SP_RST;
      sp_value_r              <= CPMC_SP_RST;
    end else if (ce) begin
      main_stack_pointer_r    <= main_stack_pointer_nxt;
      process_stack_pointer_r <= process_stack_pointer_nxt;
      sp_value_r              <= sp_value_nxt;
    end
  end

  assign sp_value = sp_value_r;
  assign main_sp  = main_stack_pointer_r;
  assign proc_sp  = process_stack_pointer_r;
endmodule

/* File: rtl/cpmc_top.sv */
/*
  Privilege level and operating mode control for a 32-bit core:
  state tracking, fault on restricted access, stack selection,
  encoding check, bit-band lock, unaligned and region decode.
  Assumes core pipeline supplies one-cycle request strobes on ref_clk.
*/
`timescale 1ns/1ps
// What this block does
// - Only privileged handler, privileged thread or user thread ever occur.
// - Servicing an exception: handler mode, always privileged; else thread.
// - User level: restricted instructions or register accesses fault.
// - Privileged level: everything allowed, no privilege fault.
// - Two stack pointers, main and process, chosen by mode and control bit 1.
// - External reset is active low, pulled up when undriven.
// - Only 16-bit and 32-bit compact encodings accepted; legacy set faults.
// - Bit-band accesses are atomic; no other access intervenes.
// - Unaligned data accesses permitted at any byte address.
// - 4 GB space decoded into code, data, peripheral regions, own buses; the block only reports address bits 31:29 on acc_region, with no buses.
// - Control bit 0: zero privileged thread, one user thread.
// - Control bit 1 selects process stack; forced zero in handler mode.
// - Status bit 24 stays one; an attempt to clear it faults.
module cpmc_top
  import cpmc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  // External reset pin, already pulled up on the pad
  input  wire logic        external_reset_n,
  // Exception sequencing from the interrupt logic
  input  wire logic        exc_entry,
  input  wire logic        exc_return,
  // Instruction decode request
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_half,
  input  wire logic        instr_legacy,
  input  wire logic        instr_restricted,
  // Special register writes (control, status, stack)
  input  wire logic        ctrl_wr,
  input  wire logic [1:0]  ctrl_wdata,
  input  wire logic        esr_wr,
  input  wire logic [31:0] esr_wdata,
  input  wire logic        sp_wr,
  input  wire logic [31:0] sp_wdata,
  // Data access request
  input  wire logic        acc_valid,
  input  wire logic [31:0] acc_addr,
  input  wire logic        acc_sys,
  input  wire logic        acc_bitband,
  // State and fault outputs
  output logic [1:0]  state,
  output logic        privileged,
  output logic        handler_mode,
  output logic [1:0]  control,
  output logic [31:0] execution_status_register,
  output logic [31:0] stack_pointer,
  output logic        fault,
  output logic        instr_wide,
  // Access routing
  output logic        acc_grant,
  output logic [2:0]  acc_region,
  output logic        acc_unaligned,
  output logic        bb_locked
);
  // Reset release and pin synchronisers
  logic [1:0] rst_sync_r, rst_sync_nxt;
  logic       rst_n;
  logic [1:0] external_reset_n_sync_r, external_reset_n_sync_nxt;

  // Next values of both two-flop chains
  always_comb begin
    rst_sync_nxt  = {rst_sync_r[0], 1'b1};
    external_reset_n_sync_nxt = {external_reset_n_sync_r[0], external_reset_n};
  end

  // Reset release: asserts at once, lets go two edges later
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= rst_sync_nxt;
    end
  end
  assign rst_n = rst_sync_r[1];

  // External reset pin passes two flops before use
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      external_reset_n_sync_r <= 2'h3;
    end else if (ce) begin
      external_reset_n_sync_r <= external_reset_n_sync_nxt;
    end
  end

  // Block state, next values and decode helpers
  cpmc_state_e state_r, state_nxt;
  logic [1:0]  ctrl_r, ctrl_nxt;
  logic [31:0] esr_r, esr_nxt;
  logic        fault_r, fault_nxt;
  logic        wide_r, wide_nxt;
  logic        half2_r, half2_nxt;
  logic        grant_r, grant_nxt;
  logic [2:0]  region_r, region_nxt;
  logic        unal_r, unal_nxt;
  logic [1:0]  bb_cnt_r, bb_cnt_nxt;
  logic        priv_r, priv_nxt;
  logic        hand_r, hand_nxt;
  logic        lock_r, lock_nxt;
  logic        is_user, is_handler, sel_proc, sp_we, soft_rst;
  logic        ctrl_wr_ok, esr_wr_ok, sp_wr_ok, priv_fault, esr_fault;
  logic        enc_fault, prefix;

  // Decode the current level and mode
  assign soft_rst   = !external_reset_n_sync_r[1];
  assign is_user    = (state_r == CPMC_USER_THREAD);
  assign is_handler = (state_r == CPMC_PRIV_HANDLR);
  // Process stack only in thread mode with the select bit set
  assign sel_proc   = !is_handler && ctrl_r[CPMC_CTRL_SPSEL];
  assign sp_we      = sp_wr && !is_user;

  // Level/mode sequencing and control register
  always_comb begin
    state_nxt = state_r;
    ctrl_nxt  = ctrl_r;
    if (ctrl_wr_ok) begin
      ctrl_nxt = ctrl_wdata;
      if (is_handler) begin
        ctrl_nxt[CPMC_CTRL_SPSEL] = 1'b0;
      end
    end
    if (exc_entry) begin
      state_nxt = CPMC_PRIV_HANDLR;
      ctrl_nxt[CPMC_CTRL_SPSEL] = 1'b0;
    end else if (exc_return && is_handler) begin
      state_nxt = ctrl_nxt[CPMC_CTRL_NPRIV] ? CPMC_USER_THREAD
                                            : CPMC_PRIV_THREAD;
    end else if (!is_handler) begin
      state_nxt = ctrl_nxt[CPMC_CTRL_NPRIV] ? CPMC_USER_THREAD
                                            : CPMC_PRIV_THREAD;
    end
    case (state_nxt)
      CPMC_PRIV_THREAD, CPMC_USER_THREAD, CPMC_PRIV_HANDLR: ;
      default: state_nxt = CPMC_PRIV_THREAD;
    endcase
    if (soft_rst) begin
      state_nxt = CPMC_PRIV_THREAD;
      ctrl_nxt  = CPMC_CTRL_RST;
    end
    // Level and mode pins follow the next state, so they stay flops
    priv_nxt = (state_nxt != CPMC_USER_THREAD);
    hand_nxt = (state_nxt == CPMC_PRIV_HANDLR);
  end

  // Register level, mode and control; ce freezes them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= CPMC_PRIV_THREAD;
      ctrl_r  <= CPMC_CTRL_RST;
      priv_r  <= 1'b1;
      hand_r  <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      ctrl_r  <= ctrl_nxt;
      priv_r  <= priv_nxt;
      hand_r  <= hand_nxt;
    end
  end

  // Privilege checks and encoding checks
  always_comb begin
    ctrl_wr_ok = ctrl_wr && !is_user;
    esr_wr_ok  = esr_wr && !is_user;
    sp_wr_ok   = sp_we;
    priv_fault = is_user && ((instr_valid && instr_restricted) ||
                 ctrl_wr || esr_wr || sp_wr ||
                 (acc_valid && acc_sys));
    esr_fault  = esr_wr_ok && !esr_wdata[CPMC_ESR_TBIT];
    enc_fault  = instr_valid && instr_legacy;
    prefix     = (instr_half[15:11] == CPMC_WIDE_PFX0) ||
                 (instr_half[15:11] == CPMC_WIDE_PFX1) ||
                 (instr_half[15:11] == CPMC_WIDE_PFX2);
    fault_nxt  = !soft_rst && (priv_fault || esr_fault || enc_fault);
  end

  // Status register and instruction width tracking
  always_comb begin
    esr_nxt = esr_r;
    if (esr_wr_ok) begin
      esr_nxt = esr_wdata;
    end
    esr_nxt[CPMC_ESR_TBIT] = 1'b1;
    half2_nxt = half2_r;
    // Pulse only in the cycle after a completed pair
    wide_nxt  = 1'b0;
    if (instr_valid && !instr_legacy) begin
      // Second halfword of a 32-bit encoding ends the pair
      wide_nxt  = half2_r;
      half2_nxt = !half2_r && prefix;
    end
    // A legacy word breaks any half-finished pair
    if (instr_valid && instr_legacy) begin
      half2_nxt = 1'b0;
    end
    if (soft_rst || exc_entry) begin
      esr_nxt   = CPMC_ESR_RST;
      half2_nxt = 1'b0;
      wide_nxt  = 1'b0;
    end
  end

  // Register status and width tracking
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      esr_r   <= CPMC_ESR_RST;
      wide_r  <= 1'b0;
      half2_r <= 1'b0;
    end else if (ce) begin
      esr_r   <= esr_nxt;
      wide_r  <= wide_nxt;
      half2_r <= half2_nxt;
    end
  end

  // Register the fault pulse, one cycle after the request
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_r <= 1'b0;
    end else if (ce) begin
      fault_r <= fault_nxt;
    end
  end

  // Data access: region decode, bit-band lock, alignment flag
  always_comb begin
    bb_cnt_nxt = (bb_cnt_r != 2'h0) ? bb_cnt_r - 2'h1 : 2'h0;
    grant_nxt  = 1'b0;
    region_nxt = region_r;
    unal_nxt   = unal_r;
    if (acc_valid && (bb_cnt_r == 2'h0) && !(is_user && acc_sys)) begin
      grant_nxt  = 1'b1;
      region_nxt = acc_addr[31:29];
      unal_nxt   = (acc_addr[1:0] != 2'h0);
      if (acc_bitband && ((acc_addr[31:24] == CPMC_BB_SRAM) ||
                          (acc_addr[31:24] == CPMC_BB_PERI))) begin
        bb_cnt_nxt = 2'(CPMC_BB_LOCK_CYC);
      end
    end
    if (soft_rst) begin
      bb_cnt_nxt = 2'h0;
      grant_nxt  = 1'b0;
    end
    // Lock pin is a flop copy of the counter's next value
    lock_nxt = (bb_cnt_nxt != 2'h0);
  end

  // Register routing and lock; ce freezes them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      grant_r  <= 1'b0;
      region_r <= CPMC_REG_CODE;
      unal_r   <= 1'b0;
      bb_cnt_r <= 2'h0;
      lock_r   <= 1'b0;
    end else if (ce) begin
      grant_r  <= grant_nxt;
      region_r <= region_nxt;
      unal_r   <= unal_nxt;
      bb_cnt_r <= bb_cnt_nxt;
      lock_r   <= lock_nxt;
    end
  end

  // Banked stack pointers
  cpmc_sp_bank u_sp (
    .clk         (ref_clk),
    .rst_n       (rst_n),
    .ce          (ce),
    .sel_process (sel_proc),
    .wr_en       (sp_wr_ok),
    .wr_data     (sp_wdata),
    .sp_value    (stack_pointer),
    .main_sp     (),
    .proc_sp     ()
  );

  // Outputs straight from flops
  assign state        = state_r;
  assign privileged   = priv_r;
  assign handler_mode = hand_r;
  assign control      = ctrl_r;
  assign execution_status_register = esr_r;
  assign fault        = fault_r;
  assign instr_wide   = wide_r;
  assign acc_grant    = grant_r;
  assign acc_region   = region_r;
  assign acc_unaligned = unal_r;
  assign bb_locked    = lock_r;
endmodule

/* File: tb/cpmc_checker.sv */
/* Assertions on the ports of cpmc_top.
   Assumes binding onto cpmc_top, one clock, rstn active low. */
`timescale 1ns/1ps
module cpmc_checker
  import cpmc_pkg::*;
(
  // Clock and control inputs
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        ce,
  input wire logic        exc_entry,
  input wire logic        exc_return,
  input wire logic        instr_valid,
  input wire logic        instr_legacy,
  input wire logic        instr_restricted,
  input wire logic        ctrl_wr,
  input wire logic [1:0]  ctrl_wdata,
  input wire logic        esr_wr,
  input wire logic [31:0] esr_wdata,
  input wire logic        acc_valid,
  input wire logic [31:0] acc_addr,
  input wire logic        acc_sys,
  // Watched outputs
  input wire logic [1:0]  state,
  input wire logic        privileged,
  input wire logic        handler_mode,
  input wire logic [1:0]  control,
  input wire logic [31:0] execution_status_register,
  input wire logic        fault,
  input wire logic        acc_grant,
  input wire logic [2:0]  acc_region,
  input wire logic        bb_locked
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Restricted request made at user level, stack pointer writes aside
  sequence user_req;
    ce && !privileged && (ctrl_wr || esr_wr || (acc_valid && acc_sys)
      || (instr_valid && instr_restricted));
  endsequence
  chk_state_legal: assert property (state != 2'h3)
    else $error("illegal state");
  chk_handler_priv: assert property (
    handler_mode |-> privileged && state == CPMC_PRIV_HANDLR)
    else $error("handler not privileged");
  chk_user_fault: assert property (user_req |=> fault)
    else $error("no fault on user request");
  chk_priv_quiet: assert property (
    ce && privileged && instr_valid && instr_restricted && !instr_legacy
    && !esr_wr |=> !fault)
    else $error("fault at privileged level");
  chk_legacy_fault: assert property (
    ce && instr_valid && instr_legacy |=> fault)
    else $error("legacy encoding accepted");
  chk_bb_block: assert property (
    ce && acc_valid && bb_locked |=> !acc_grant)
    else $error("grant during lock");
  chk_region_map: assert property (
    ce && acc_valid && !acc_sys && !bb_locked
    |=> acc_grant && acc_region == $past(acc_addr[31:29]))
    else $error("bad region or no grant");
  chk_thread_level: assert property (
    ce && ctrl_wr && privileged && !handler_mode && !exc_entry
    |=> state[0] == $past(ctrl_wdata[0]))
    else $error("thread level not from control");
  chk_handler_stack: assert property (handler_mode |-> !control[1])
    else $error("alternate stack in handler");
  chk_tbit_kept: assert property (
    execution_status_register[24] ##0
    (ce && privileged && esr_wr && !esr_wdata[24]) |=> fault)
    else $error("status bit clear not faulted");
  chk_entry_main: assert property (
    ce && exc_entry |=> state == CPMC_PRIV_HANDLR && !control[1])
    else $error("bad exception entry");
  chk_return_thread: assert property (
    ce && exc_return && !exc_entry && handler_mode
    |=> !handler_mode && state[0] == control[0])
    else $error("bad exception return");
endmodule

bind cpmc_top cpmc_checker i_chk (.*);

/* File: tb/cpmc_top_test.sv */
/* Self-checking bench for cpmc_top.
   Assumes the checker is bound separately; ce held high except in t_hold. */
`timescale 1ns/1ps
module cpmc_top_test;
  import cpmc_pkg::*;
  logic        ref_clk = 0, rstn = 0, ce = 1, external_reset_n = 1;
  logic        exc_entry = 0, exc_return = 0, instr_valid = 0;
  logic        instr_legacy = 0, instr_restricted = 0;
  logic        ctrl_wr = 0, esr_wr = 0, sp_wr = 0;
  logic        acc_valid = 0, acc_sys = 0, acc_bitband = 0;
  logic [15:0] instr_half = 16'h0000;
  logic [1:0]  ctrl_wdata = 2'h0, state, control;
  logic [31:0] esr_wdata = 32'h0, sp_wdata = 32'h0, acc_addr = 32'h0;
  logic [31:0] execution_status_register, stack_pointer;
  logic        privileged, handler_mode, fault, instr_wide;
  logic        acc_grant, acc_unaligned, bb_locked;
  logic [2:0]  acc_region;
  int          mismatches = 0, n_compared = 0, cycles = 0;

  cpmc_top i_dut (.*);

  // Clock
  always #12.5 ref_clk = ~ref_clk;
  // Cycle ceiling against hangs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      complete_run();
    end
  end
  // Wait edges, then step past them
  task automatic cyc(int n = 1);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  // One comparison
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Values straight after reset
  task automatic t_reset();
    check("state", CPMC_PRIV_THREAD, state);
    check("control", 0, control);
    check("esr", CPMC_ESR_RST, execution_status_register);
    check("sp", CPMC_SP_RST, stack_pointer);
    check("priv", 1, privileged);
    check("handler", 0, handler_mode);
    $display("t_reset done");
  endtask
  // Privileged restricted work, unaligned access
  task automatic t_priv();
    instr_valid = 1;
    instr_restricted = 1;
    acc_valid = 1;
    acc_sys = 1;
    acc_addr = 32'h40000003;
    cyc();
    instr_valid = 0;
    instr_restricted = 0;
    acc_valid = 0;
    acc_sys = 0;
    check("fault", 0, fault);
    check("grant", 1, acc_grant);
    check("region", 3'h2, acc_region);
    check("unaligned", 1, acc_unaligned);
    cyc();
    $display("t_priv done");
  endtask
  // Wide prefixes, then a legacy encoding
  task automatic t_encode();
    logic [4:0] pfx [3] = '{CPMC_WIDE_PFX0, CPMC_WIDE_PFX1, CPMC_WIDE_PFX2};
    instr_valid = 1;
    foreach (pfx[i]) begin
      instr_half = {pfx[i], 11'h000};
      cyc();
      check("wide", 0, instr_wide);
      instr_half = 16'h0000;
      cyc();
      check("wide", 1, instr_wide);
    end
    instr_legacy = 1;
    cyc();
    instr_valid = 0;
    instr_legacy = 0;
    check("fault", 1, fault);
    check("wide", 0, instr_wide);
    esr_wr = 1;
    cyc();
    esr_wr = 0;
    check("fault", 1, fault);
    check("tbit", 1, execution_status_register[24]);
    $display("t_encode done");
  endtask
  // Banked pointers across an exception
  task automatic t_stack();
    sp_wr = 1;
    sp_wdata = 32'h00001000;
    cyc();
    sp_wr = 0;
    ctrl_wr = 1;
    ctrl_wdata = 2'h2;
    cyc();
    ctrl_wr = 0;
    cyc();
    check("sp", 0, stack_pointer);
    sp_wr = 1;
    sp_wdata = 32'h00002004;
    cyc();
    sp_wr = 0;
    exc_entry = 1;
    cyc();
    exc_entry = 0;
    check("state", CPMC_PRIV_HANDLR, state);
    check("handler", 1, handler_mode);
    check("control", 0, control);
    ctrl_wr = 1;
    cyc();
    ctrl_wr = 0;
    check("sp", 32'h00001000, stack_pointer);
    check("control", 0, control);
    exc_return = 1;
    cyc();
    exc_return = 0;
    check("state", CPMC_PRIV_THREAD, state);
    $display("t_stack done");
  endtask
  // User level refusals and exception round trip
  task automatic t_user();
    ctrl_wr = 1;
    ctrl_wdata = 2'h1;
    cyc();
    check("state", CPMC_USER_THREAD, state);
    ctrl_wdata = 2'h0;
    acc_addr = 32'hE0000000;
    for (int k = 0; k < 3; k++) begin
      ctrl_wr = (k == 0);
      acc_valid = (k == 1);
      acc_sys = (k == 1);
      instr_valid = (k == 2);
      instr_restricted = (k == 2);
      cyc();
      check("fault", 1, fault);
      check("grant", 0, acc_grant);
    end
    instr_valid = 0;
    instr_restricted = 0;
    check("control", 2'h1, control);
    exc_entry = 1;
    cyc();
    exc_entry = 0;
    check("priv", 1, privileged);
    ctrl_wr = 1;
    cyc();
    ctrl_wr = 0;
    check("fault", 0, fault);
    exc_return = 1;
    cyc();
    exc_return = 0;
    check("state", CPMC_PRIV_THREAD, state);
    $display("t_user done");
  endtask
  // Bit-band lock holds off the next access
  task automatic t_bitband();
    int n;
    acc_valid = 1;
    acc_bitband = 1;
    acc_addr = 32'h22000004;
    cyc();
    check("grant", 1, acc_grant);
    check("locked", 1, bb_locked);
    check("unaligned", 0, acc_unaligned);
    acc_bitband = 0;
    acc_addr = 32'h20000000;
    cyc();
    check("grant", 0, acc_grant);
    for (n = 0; n < 4 && acc_grant !== 1'b1; n++)
      cyc();
    acc_valid = 0;
    check("grant", 1, acc_grant);
    check("lock", CPMC_BB_LOCK_CYC, n);
    $display("t_bitband done");
  endtask
  // Clock enable low freezes the state
  task automatic t_hold();
    ce = 0;
    ctrl_wr = 1;
    ctrl_wdata = 2'h1;
    cyc();
    ce = 1;
    ctrl_wr = 0;
    cyc();
    check("state", CPMC_PRIV_THREAD, state);
    check("control", 0, control);
    $display("t_hold done");
  endtask
  // Pin reset returns to privileged thread
  task automatic t_pin_reset();
    ctrl_wr = 1;
    ctrl_wdata = 2'h1;
    cyc();
    ctrl_wr = 0;
    external_reset_n = 0;
    cyc(4);
    external_reset_n = 1;
    cyc(3);
    check("state", CPMC_PRIV_THREAD, state);
    check("control", 0, control);
    $display("t_pin_reset done");
  endtask
  // Main sequence
  initial begin
    cyc(4);
    rstn = 1;
    cyc(3);
    t_reset();
    t_priv();
    t_encode();
    t_stack();
    t_user();
    t_bitband();
    t_hold();
    t_pin_reset();
    complete_run();
  end
endmodule
